/* File: dv/ecp_coproc_port_tb.sv */
// ecp_coproc_port_tb: directed self-checking bench for the coprocessor issue port.
// assumes ecp_cp_model answers on the coprocessor side; inputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module ecp_coproc_port_tb
    import ecp_pkg::*;
;
    logic ref_clk_in = 0, reset_in = 1, issue_valid_in = 0, priv_in = 0, nonsecure_in = 0;
    logic lsu_complete_in = 0, irq_pending_in = 0, err_en = 0;
    logic [31:0] instr_word_in = 0, rt_data_in = 0, rt2_data_in = 0, cp_instr_out;
    logic [7:0] coproc_present_in = 8'hbf, coproc_access_ctrl_s_in = 8'hff;
    logic [7:0] coproc_access_ctrl_ns_in = 8'hff, nonsecure_access_ctrl_in = 8'hdf;
    logic [7:0] route_to_cde_in = 8'h80, coproc_instr_valid_out, coproc_commit_out;
    logic [7:0] coproc_cancel_out, coproc_stall_wait_in, coproc_error_resp_in;
    logic [7:0][63:0] coproc_rdata_in;
    logic [63:0] rd_val = 0, cp_wdata_out, result_data_out;
    logic [3:0] stall_len = 0, condition_flags_out, result_rt_out, result_rt2_out;
    logic [2:0] cde_cp_out;
    logic issue_ready_out, cp_priv_out, cp_nonsecure_out, result_valid_out, flags_write_out;
    logic cde_issue_out, absent_coproc_fault_out, undefined_instr_fault_out, irq_take_out;
    logic result_pair_out;
    ecp_kind_t cp_kind_out;
    int n_mismatch = 0, compares = 0;
    time t0;
    always #12.5 ref_clk_in = ~ref_clk_in;
    ecp_coproc_port u_ecp_coproc_port (.ref_clk_in, .reset_in, .issue_valid_in,
        .issue_ready_out, .instr_word_in, .priv_in, .nonsecure_in, .rt_data_in, .rt2_data_in,
        .coproc_present_in, .coproc_access_ctrl_s_in, .coproc_access_ctrl_ns_in,
        .nonsecure_access_ctrl_in, .route_to_cde_in, .lsu_complete_in, .irq_pending_in,
        .coproc_instr_valid_out, .coproc_commit_out, .coproc_cancel_out, .cp_priv_out,
        .cp_nonsecure_out, .cp_kind_out, .cp_instr_out, .cp_wdata_out, .coproc_stall_wait_in,
        .coproc_error_resp_in, .coproc_rdata_in, .result_valid_out, .result_pair_out,
        .result_rt_out, .result_rt2_out, .result_data_out, .flags_write_out,
        .condition_flags_out, .cde_issue_out, .cde_cp_out, .absent_coproc_fault_out,
        .undefined_instr_fault_out, .irq_take_out);
    ecp_cp_model u_ecp_cp_model (.ref_clk_in, .valid_in(coproc_instr_valid_out),
        .stall_len_in(stall_len), .err_en_in(err_en), .rd_val_in(rd_val),
        .stall_out(coproc_stall_wait_in), .err_out(coproc_error_resp_in),
        .rdata_out(coproc_rdata_in));
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [3:0] ans();
        return {|coproc_instr_valid_out, absent_coproc_fault_out,
                undefined_instr_fault_out, cde_issue_out};
    endfunction : ans
    // called at a falling edge; returns at the falling edge after the take, valid still high
    task automatic issue(input logic [31:0] w);
        issue_valid_in = 1'b1;
        instr_word_in  = w;
        for (int i = 0; i < 20 && issue_ready_out !== 1'b1; i++)
            @(negedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask : issue
    task automatic drop();
        issue_valid_in = 1'b0;
        @(negedge ref_clk_in);
    endtask : drop
    task automatic t_move_to();
        priv_in = 1;
        rt_data_in = 32'h1234_5678;
        issue(32'hEE00_3210);
        chk(coproc_instr_valid_out, 8'h04);
        chk({cp_priv_out, cp_nonsecure_out, cp_kind_out}, {2'b10, K_MOVE_TO});
        chk(cp_wdata_out[31:0], 32'h1234_5678);
        chk(cp_instr_out, 32'hEE00_3210);
        drop();
        chk(coproc_commit_out, 8'h04);
        issue(32'hEE00_0200);
        chk(cp_kind_out, K_DATAPROC);
        drop();
    endtask : t_move_to
    task automatic t_flags();
        rd_val = 64'h0000_0000_9000_0001;
        issue(32'hFE10_F110);
        chk({cp_instr_out[28], cp_kind_out}, {1'b0, K_MOVE_FROM});
        drop();
        chk({flags_write_out, result_valid_out, condition_flags_out}, 6'h29);
    endtask : t_flags
    task automatic t_pair_b2b();
        rd_val = 64'hCAFE_0001_BEEF_0002;
        issue(32'hEC52_1310);
        t0 = $time;
        issue(32'hEC52_1310);
        chk($time - t0, 25);
        chk({result_valid_out, result_data_out}, {1'b1, rd_val});
        chk({result_pair_out, result_rt_out, result_rt2_out}, 9'h112);
        drop();
        chk({result_valid_out, coproc_commit_out}, 9'h108);
    endtask : t_pair_b2b
    task automatic t_stall();
        stall_len = 3;
        issue(32'hEE00_3010);
        @(negedge ref_clk_in);
        irq_pending_in = 1;
        chk(coproc_commit_out, 8'h00);
        drop();
        irq_pending_in = 0;
        chk({irq_take_out, coproc_cancel_out}, 9'h101);
        stall_len = 2;
        issue(32'hEE00_3010);
        drop();
        repeat (2) @(negedge ref_clk_in);
        chk(coproc_commit_out, 8'h01);
        stall_len = 0;
        err_en = 1;
        issue(32'hEE00_3410);
        drop();
        err_en = 0;
        chk({undefined_instr_fault_out, coproc_commit_out}, 9'h100);
    endtask : t_stall
    task automatic fault_case(input logic ns, input logic [31:0] w, input logic [3:0] exp);
        nonsecure_in = ns;
        issue(w);
        chk(ans(), exp);
        drop();
    endtask : fault_case
    task automatic t_gap();
        lsu_complete_in = 1;
        @(negedge ref_clk_in);
        lsu_complete_in = 0;
        chk(issue_ready_out, 1'b0);
        @(negedge ref_clk_in);
        chk(issue_ready_out, 1'b1);
    endtask : t_gap
    task automatic end_sim();
        if (n_mismatch == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (4) @(negedge ref_clk_in);
        reset_in = 0;
        @(negedge ref_clk_in);
        t_move_to();
        t_flags();
        t_pair_b2b();
        t_stall();
        fault_case(0, 32'hED90_0500, 4'h2);
        fault_case(0, 32'hEE00_D510, 4'h2);
        fault_case(0, 32'hEC4D_3500, 4'h2);
        fault_case(0, 32'hEE00_3610, 4'h4);
        fault_case(1, 32'hEE00_3510, 4'h4);
        fault_case(0, 32'hEE00_3710, 4'h1);
        chk(cde_cp_out, 3'h7);
        t_gap();
        end_sim();
    end
    initial
    begin
        #50000;
        n_mismatch++;
        end_sim();
    end
endmodule : ecp_coproc_port_tb
`default_nettype wire

/* File: dv/ecp_cp_model.sv */
// ecp_cp_model: behavioural coprocessor on the far side of the issue port.
// assumes one instruction outstanding at a time and the shared ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
module ecp_cp_model
    import ecp_pkg::*;
(
    input  wire logic                          ref_clk_in,
    input  wire logic [CP_NUM-1:0]             valid_in,
    input  wire logic [3:0]                    stall_len_in,
    input  wire logic                          err_en_in,
    input  wire logic [PAIR_W-1:0]             rd_val_in,
    output logic      [CP_NUM-1:0]             stall_out,
    output logic      [CP_NUM-1:0]             err_out,
    output logic      [CP_NUM-1:0][PAIR_W-1:0] rdata_out
);
    logic [3:0] busy_cnt_ff;
    always_ff @(posedge ref_clk_in)
        busy_cnt_ff <= (valid_in == '0) ? 4'h0 : busy_cnt_ff + 4'h1;
    always_comb
    begin
        for (int n = 0; n < CP_NUM; n++)
        begin
            stall_out[n] = valid_in[n] && (busy_cnt_ff < stall_len_in);
            err_out[n]   = valid_in[n] && err_en_in;
            // idle lanes show the inverse so a stale word never passes as a reply
            rdata_out[n] = (valid_in[n] && !stall_out[n]) ? rd_val_in : ~rd_val_in;
        end
    end
endmodule : ecp_cp_model
`default_nettype wire

/* File: hw/ecp_coproc_port.sv */
// ecp_coproc_port: processor-side issue port to up to eight external coprocessors.
// assumes the pipeline, the coprocessors and the load/store unit share ref_clk_in.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1: each of eight coprocessors has its own valid, commit, cancel, reply and data lines.
// RQ2: issued instruction carries privilege, security state, kind and its architected fields.
// RQ3: supported kinds are moves to coprocessor, moves from it, and data processing.
// RQ4: a commit pulse tells the coprocessor the instruction is final and uninterruptible.
// RQ5: coprocessor may busy-wait the processor; interrupts still abandon the wait.
// RQ6: an error reply while waiting raises an undefined-instruction fault.
// RQ7: both encodings, differing only in the variant bit, behave the same.
// RQ8: single move from coprocessor naming register 15 loads the condition flags.
// RQ9: with no busy-wait, back-to-back moves sustain one word or pair per cycle.
// RQ10: coprocessor memory loads and stores on an enabled coprocessor fault as undefined.
// RQ11: transfers naming the stack pointer on an enabled coprocessor fault as undefined.
// RQ12: absent or disabled coprocessor gives the no-coprocessor fault.
// RQ13: no path exists to read or write coprocessor registers for debug.
// RQ14: coprocessor should expose its registers on its own peripheral slave port.
// RQ15: coprocessor hides secure data from non-secure debug using bus attributes.
// RQ16: coprocessor registers are never saved or restored on exceptions.
// RQ17: coprocessor keeps secure data away from non-secure handlers.
// RQ18: coprocessor must not rely on a synchronous fault after an error reply.
// RQ19: coprocessor issue waits one cycle after a load or store completes.
// RQ20: that cycle overlaps the load-use stall rather than adding to it.
// RQ21: each coprocessor number goes to the external port or the datapath, never both.
module ecp_coproc_port
    import ecp_pkg::*;
(
    input  wire logic                           ref_clk_in,
    input  wire logic                           reset_in,
    // pipeline issue side
    input  wire logic                           issue_valid_in,
    output logic                                issue_ready_out,
    input  wire logic [INSTR_W-1:0]             instr_word_in,
    input  wire logic                           priv_in,
    input  wire logic                           nonsecure_in,
    input  wire logic [DATA_W-1:0]              rt_data_in,
    input  wire logic [DATA_W-1:0]              rt2_data_in,
    input  wire logic [CP_NUM-1:0]              coproc_present_in,
    input  wire logic [CP_NUM-1:0]              coproc_access_ctrl_s_in,
    input  wire logic [CP_NUM-1:0]              coproc_access_ctrl_ns_in,
    input  wire logic [CP_NUM-1:0]              nonsecure_access_ctrl_in,
    input  wire logic [CP_NUM-1:0]              route_to_cde_in,
    input  wire logic                           lsu_complete_in,
    input  wire logic                           irq_pending_in,
    // coprocessor side
    output logic      [CP_NUM-1:0]              coproc_instr_valid_out,
    output logic      [CP_NUM-1:0]              coproc_commit_out,
    output logic      [CP_NUM-1:0]              coproc_cancel_out,
    output logic                                cp_priv_out,
    output logic                                cp_nonsecure_out,
    output ecp_kind_t                           cp_kind_out,
    output logic      [INSTR_W-1:0]             cp_instr_out,
    output logic      [PAIR_W-1:0]              cp_wdata_out,
    input  wire logic [CP_NUM-1:0]              coproc_stall_wait_in,
    input  wire logic [CP_NUM-1:0]              coproc_error_resp_in,
    input  wire logic [CP_NUM-1:0][PAIR_W-1:0]  coproc_rdata_in,
    // results, faults and datapath hand-off
    output logic                                result_valid_out,
    output logic                                result_pair_out,
    output logic      [FIELD_W-1:0]             result_rt_out,
    output logic      [FIELD_W-1:0]             result_rt2_out,
    output logic      [PAIR_W-1:0]              result_data_out,
    output logic                                flags_write_out,
    output logic      [FLAGS_W-1:0]             condition_flags_out,
    output logic                                cde_issue_out,
    output logic      [CPN_W-1:0]               cde_cp_out,
    output logic                                absent_coproc_fault_out,
    output logic                                undefined_instr_fault_out,
    output logic                                irq_take_out
);

    // no register access path and no state save exists here by design [RQ13] [RQ16]

    ecp_kind_t    dec_kind;
    logic [FIELD_W-1:0] dec_cp;
    logic [FIELD_W-1:0] dec_rt;
    logic [FIELD_W-1:0] dec_rt2;

    ecp_decode u_decode (
        .instr_word_in (instr_word_in),
        .kind_out      (dec_kind),
        .cp_num_out    (dec_cp),
        .rt_out        (dec_rt),
        .rt2_out       (dec_rt2)
    );

    ecp_state_t          state_ff,   nxt_state;
    ecp_kind_t           kind_ff,    nxt_kind;
    logic [CP_NUM-1:0]   valid_ff,   nxt_valid;
    logic [CP_NUM-1:0]   commit_ff,  nxt_commit;
    logic [CP_NUM-1:0]   cancel_ff,  nxt_cancel;
    logic [CPN_W-1:0]    cur_cp_ff,  nxt_cur_cp;
    logic [FIELD_W-1:0]  rt_ff,      nxt_rt;
    logic [FIELD_W-1:0]  rt2_ff,     nxt_rt2;
    logic [INSTR_W-1:0]  instr_ff,   nxt_instr;
    logic [PAIR_W-1:0]   wdata_ff,   nxt_wdata;
    logic                priv_ff,    nxt_priv;
    logic                ns_ff,      nxt_ns;
    logic                ls_gap_ff,  nxt_ls_gap;
    logic                res_vld_ff, nxt_res_vld;
    logic                res_pair_ff, nxt_res_pair;
    logic [FIELD_W-1:0]  res_rt_ff,  nxt_res_rt;
    logic [FIELD_W-1:0]  res_rt2_ff, nxt_res_rt2;
    logic [PAIR_W-1:0]   res_data_ff, nxt_res_data;
    logic                flag_wr_ff, nxt_flag_wr;
    logic [FLAGS_W-1:0]  flags_ff,   nxt_flags;
    logic                cde_ff,     nxt_cde;
    logic [CPN_W-1:0]    cde_cp_ff,  nxt_cde_cp;
    logic                absent_ff,  nxt_absent;
    logic                undef_ff,   nxt_undef;
    logic                irq_tk_ff,  nxt_irq_tk;

    logic [CPN_W-1:0]    cpi;
    logic                cp_enabled;
    logic                is_pair;
    logic                uses_sp;
    logic                busy;
    logic                sel_stall;
    logic                sel_err;
    logic                accept;
    logic                take;
    logic [PAIR_W-1:0]   sel_rdata;
    logic [INSTR_W-1:0]  instr_clean;

    always_comb
    begin
        cpi        = dec_cp[CPN_W-1:0];
        // numbers 8..15 are never served here; they read as absent
        cp_enabled = (dec_cp < CP_LIMIT) && coproc_present_in[cpi]
                     && (nonsecure_in ? (coproc_access_ctrl_ns_in[cpi]
                                         && nonsecure_access_ctrl_in[cpi])
                                      : coproc_access_ctrl_s_in[cpi]);
        is_pair    = (dec_kind == K_PAIR_TO) || (dec_kind == K_PAIR_FROM);
        uses_sp    = ((dec_kind == K_MOVE_TO) || (dec_kind == K_MOVE_FROM) || is_pair)
                     && ((dec_rt == RT_SP) || (is_pair && (dec_rt2 == RT_SP))); // [RQ11]
        busy       = (state_ff == ST_WAIT);
        sel_stall  = coproc_stall_wait_in[cur_cp_ff];
        sel_err    = coproc_error_resp_in[cur_cp_ff];
        sel_rdata  = coproc_rdata_in[cur_cp_ff];
        accept     = busy && !sel_stall && !sel_err;
        // the gap after a load/store only blocks the cycle after completion; a load-use
        // stall already holds the instruction through that same cycle [RQ19] [RQ20]
        issue_ready_out = !ls_gap_ff && (!busy || accept); // [RQ9]
        take        = issue_valid_in && issue_ready_out;
        instr_clean = instr_word_in;
        instr_clean[VARIANT_BIT] = 1'b0; // [RQ7]
    end

    always_comb
    begin
        nxt_state    = state_ff;
        nxt_kind     = kind_ff;
        nxt_valid    = valid_ff;
        nxt_commit   = CP_VEC_RST;
        nxt_cancel   = CP_VEC_RST;
        nxt_cur_cp   = cur_cp_ff;
        nxt_rt       = rt_ff;
        nxt_rt2      = rt2_ff;
        nxt_instr    = instr_ff;
        nxt_wdata    = wdata_ff;
        nxt_priv     = priv_ff;
        nxt_ns       = ns_ff;
        nxt_ls_gap   = lsu_complete_in; // [RQ19]
        nxt_res_vld  = 1'b0;
        nxt_res_pair = res_pair_ff;
        nxt_res_rt   = res_rt_ff;
        nxt_res_rt2  = res_rt2_ff;
        nxt_res_data = res_data_ff;
        nxt_flag_wr  = 1'b0;
        nxt_flags    = flags_ff;
        nxt_cde      = 1'b0;
        nxt_cde_cp   = cde_cp_ff;
        nxt_absent   = 1'b0;
        nxt_undef    = 1'b0;
        nxt_irq_tk   = 1'b0;

        if (busy)
        begin
            if (sel_err)
            begin
                // fault is reported but may still lose to a higher interrupt [RQ18]
                nxt_valid = CP_VEC_RST;
                nxt_undef = 1'b1; // [RQ6]
                nxt_state = ST_IDLE;
            end
            else if (sel_stall)
            begin
                if (irq_pending_in)
                begin
                    // abandon the wait; the instruction reissues after the handler [RQ5]
                    nxt_valid  = CP_VEC_RST;
                    nxt_cancel = valid_ff;
                    nxt_irq_tk = 1'b1;
                    nxt_state  = ST_IDLE;
                end
            end
            else
            begin
                nxt_commit = valid_ff; // [RQ4]
                nxt_valid  = CP_VEC_RST;
                nxt_state  = ST_IDLE;
                if ((kind_ff == K_MOVE_FROM) && (rt_ff == RT_FLAGS))
                begin
                    nxt_flag_wr = 1'b1; // [RQ8]
                    nxt_flags   = sel_rdata[FLAGS_LSB +: FLAGS_W];
                end
                else if ((kind_ff == K_MOVE_FROM) || (kind_ff == K_PAIR_FROM))
                begin
                    nxt_res_vld  = 1'b1;
                    nxt_res_pair = (kind_ff == K_PAIR_FROM);
                    nxt_res_rt   = rt_ff;
                    nxt_res_rt2  = rt2_ff;
                    nxt_res_data = (kind_ff == K_PAIR_FROM) ? sel_rdata
                                   : {{DATA_W{1'b0}}, sel_rdata[DATA_W-1:0]};
                end
            end
        end

        if (take)
        begin
            if (!cp_enabled)
                nxt_absent = 1'b1; // [RQ12]
            else if (route_to_cde_in[cpi])
            begin
                nxt_cde    = 1'b1; // [RQ21]
                nxt_cde_cp = cpi;
            end
            else if ((dec_kind == K_MEM) || (dec_kind == K_NONE) || uses_sp)
                nxt_undef = 1'b1; // [RQ10] [RQ11]
            else
            begin
                nxt_valid  = CP_VEC_RST;
                nxt_valid[cpi] = 1'b1; // [RQ1]
                nxt_state  = ST_WAIT;
                nxt_kind   = dec_kind; // [RQ3]
                nxt_cur_cp = cpi;
                nxt_rt     = dec_rt;
                nxt_rt2    = dec_rt2;
                nxt_instr  = instr_clean; // [RQ2]
                nxt_priv   = priv_in;
                nxt_ns     = nonsecure_in;
                nxt_wdata  = {rt2_data_in, rt_data_in};
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_ff    <= ST_IDLE;
            kind_ff     <= K_NONE;
            valid_ff    <= CP_VEC_RST;
            commit_ff   <= CP_VEC_RST;
            cancel_ff   <= CP_VEC_RST;
            cur_cp_ff   <= '0;
            rt_ff       <= '0;
            rt2_ff      <= '0;
            instr_ff    <= INSTR_RST;
            wdata_ff    <= DATA_RST;
            priv_ff     <= 1'b0;
            ns_ff       <= 1'b0;
            ls_gap_ff   <= 1'b0;
            res_vld_ff  <= 1'b0;
            res_pair_ff <= 1'b0;
            res_rt_ff   <= '0;
            res_rt2_ff  <= '0;
            res_data_ff <= DATA_RST;
            flag_wr_ff  <= 1'b0;
            flags_ff    <= '0;
            cde_ff      <= 1'b0;
            cde_cp_ff   <= '0;
            absent_ff   <= 1'b0;
            undef_ff    <= 1'b0;
            irq_tk_ff   <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            kind_ff     <= nxt_kind;
            valid_ff    <= nxt_valid;
            commit_ff   <= nxt_commit;
            cancel_ff   <= nxt_cancel;
            cur_cp_ff   <= nxt_cur_cp;
            rt_ff       <= nxt_rt;
            rt2_ff      <= nxt_rt2;
            instr_ff    <= nxt_instr;
            wdata_ff    <= nxt_wdata;
            priv_ff     <= nxt_priv;
            ns_ff       <= nxt_ns;
            ls_gap_ff   <= nxt_ls_gap;
            res_vld_ff  <= nxt_res_vld;
            res_pair_ff <= nxt_res_pair;
            res_rt_ff   <= nxt_res_rt;
            res_rt2_ff  <= nxt_res_rt2;
            res_data_ff <= nxt_res_data;
            flag_wr_ff  <= nxt_flag_wr;
            flags_ff    <= nxt_flags;
            cde_ff      <= nxt_cde;
            cde_cp_ff   <= nxt_cde_cp;
            absent_ff   <= nxt_absent;
            undef_ff    <= nxt_undef;
            irq_tk_ff   <= nxt_irq_tk;
        end
    end

    assign coproc_instr_valid_out    = valid_ff;
    assign coproc_commit_out         = commit_ff;
    assign coproc_cancel_out         = cancel_ff;
    assign cp_priv_out               = priv_ff;
    assign cp_nonsecure_out          = ns_ff;
    assign cp_kind_out               = kind_ff;
    assign cp_instr_out              = instr_ff;
    assign cp_wdata_out              = wdata_ff;
    assign result_valid_out          = res_vld_ff;
    assign result_pair_out           = res_pair_ff;
    assign result_rt_out             = res_rt_ff;
    assign result_rt2_out            = res_rt2_ff;
    assign result_data_out           = res_data_ff;
    assign flags_write_out           = flag_wr_ff;
    assign condition_flags_out       = flags_ff;
    assign cde_issue_out             = cde_ff;
    assign cde_cp_out                = cde_cp_ff;
    assign absent_coproc_fault_out   = absent_ff;
    assign undefined_instr_fault_out = undef_ff;
    assign irq_take_out              = irq_tk_ff;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_issue_ok;
        take && cp_enabled && !route_to_cde_in[cpi] && !uses_sp
            && (dec_kind != K_MEM) && (dec_kind != K_NONE);
    endsequence

    sequence s_accept;
        busy && !sel_stall && !sel_err;
    endsequence

    a_valid_onehot: assert property ($onehot0(valid_ff)) // [RQ1]
        else $error("more than one coprocessor valid");
    a_commit_after_accept: assert property (s_accept |=> commit_ff == $past(valid_ff) // [RQ4]
                                            && (valid_ff != $past(valid_ff) || $past(take)))
        else $error("accepted instruction not committed");
    a_back_to_back: assert property (s_accept ##0 s_issue_ok |=> busy && $onehot(valid_ff)) // [RQ9]
        else $error("back-to-back issue lost a cycle");
    a_stall_holds: assert property (busy && sel_stall && !irq_pending_in && !sel_err
                                    |=> valid_ff == $past(valid_ff) && commit_ff == '0) // [RQ5]
        else $error("busy-wait dropped the instruction");
    a_irq_abandon: assert property (busy && sel_stall && !sel_err && irq_pending_in
                                    |=> irq_take_out && cancel_ff != '0 && valid_ff == '0) // [RQ5]
        else $error("interrupt did not end the busy-wait");
    a_error_fault: assert property (busy && sel_err
                                    |=> undefined_instr_fault_out && commit_ff == '0) // [RQ6]
        else $error("error reply without undefined fault");
    a_absent_fault: assert property (take && !cp_enabled
                                     |=> absent_coproc_fault_out && valid_ff == '0) // [RQ12]
        else $error("disabled coprocessor not faulted");
    a_mem_fault: assert property (take && cp_enabled && !route_to_cde_in[cpi]
                                  && (dec_kind == K_MEM) |=> undefined_instr_fault_out) // [RQ10]
        else $error("coprocessor memory access not faulted");
    a_gap_after_ls: assert property (lsu_complete_in |=> !issue_ready_out ##1 !ls_gap_ff
                                     || lsu_complete_in) // [RQ19]
        else $error("issue not held after load or store");
    a_cde_exclusive: assert property (take && cp_enabled && route_to_cde_in[cpi]
                                      |=> cde_issue_out && valid_ff == '0) // [RQ21]
        else $error("instruction sent to both paths");
    a_flags_load: assert property (flags_write_out |-> !result_valid_out
                                   && $past(kind_ff) == K_MOVE_FROM) // [RQ8]
        else $error("flags loaded from wrong kind");

endmodule : ecp_coproc_port

`default_nettype wire

/* File: hw/ecp_decode.sv */
// ecp_decode: classifies a coprocessor-space instruction word and extracts fields.
// assumes the word is stable while the issue stage looks at it; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module ecp_decode
    import ecp_pkg::*;
(
    input  wire logic [INSTR_W-1:0] instr_word_in,
    output ecp_kind_t               kind_out,
    output logic      [FIELD_W-1:0] cp_num_out,
    output logic      [FIELD_W-1:0] rt_out,
    output logic      [FIELD_W-1:0] rt2_out
);

    logic [15:0]      hw1;
    logic [OP1_W-1:0] op1;
    logic             is_cp;

    always_comb
    begin
        hw1        = instr_word_in[INSTR_W-1:HW1_LSB];
        op1        = instr_word_in[OP1_LSB +: OP1_W];
        cp_num_out = instr_word_in[CP_FIELD_LSB +: FIELD_W];
        rt_out     = instr_word_in[RT_FIELD_LSB +: FIELD_W];
        rt2_out    = instr_word_in[RT2_FIELD_LSB +: FIELD_W];
        // the variant bit is never looked at, so both encodings decode alike
        is_cp      = (hw1[15:13] == 3'h7) && (hw1[11:10] == 2'h3); // [RQ7]
        kind_out   = K_NONE;
        if (is_cp)
        begin
            if (op1[5:4] == 2'h2)
            begin
                if (!instr_word_in[MOVE_BIT])
                    kind_out = K_DATAPROC; // [RQ3]
                else if (op1[0])
                    kind_out = K_MOVE_FROM;
                else
                    kind_out = K_MOVE_TO;
            end
            else if (op1[5:1] == 5'h02)
                kind_out = op1[0] ? K_PAIR_FROM : K_PAIR_TO;
            else if ((op1[5] == 1'b0) && !((op1[5:3] == 3'h0) && (op1[1] == 1'b0)))
                kind_out = K_MEM;
            else
                kind_out = K_NONE;
        end
    end

endmodule : ecp_decode

`default_nettype wire

/* File: hw/ecp_pkg.sv */
// ecp_pkg: shared constants and types of the external coprocessor port.
// assumes a 32-bit thumb-style instruction word, first halfword in bits [31:16].
package ecp_pkg;

    localparam int CP_NUM    = 8;
    localparam int CPN_W     = 3;
    localparam int FIELD_W   = 4;
    localparam int DATA_W    = 32;
    localparam int PAIR_W    = 64;
    localparam int INSTR_W   = 32;
    localparam int FLAGS_W   = 4;

    // instruction field positions within the 32-bit word
    localparam int VARIANT_BIT   = 28;  // bit 12 of the first halfword
    localparam int HW1_LSB       = 16;
    localparam int CP_FIELD_LSB  = 8;
    localparam int RT_FIELD_LSB  = 12;
    localparam int RT2_FIELD_LSB = 16;
    localparam int OP1_LSB       = 20;
    localparam int OP1_W         = 6;
    localparam int MOVE_BIT      = 4;
    localparam int FLAGS_LSB     = 28;

    localparam logic [FIELD_W-1:0] CP_LIMIT = 4'h8;
    localparam logic [FIELD_W-1:0] RT_SP    = 4'hd;
    localparam logic [FIELD_W-1:0] RT_FLAGS = 4'hf;

    // reset values
    localparam logic [CP_NUM-1:0]  CP_VEC_RST = 8'h00;
    localparam logic [PAIR_W-1:0]  DATA_RST   = 64'h0000_0000_0000_0000;
    localparam logic [INSTR_W-1:0] INSTR_RST  = 32'h0000_0000;

    typedef enum logic [2:0] {
        K_NONE,
        K_MOVE_TO,
        K_MOVE_FROM,
        K_PAIR_TO,
        K_PAIR_FROM,
        K_DATAPROC,
        K_MEM
    } ecp_kind_t;

    typedef enum logic {
        ST_IDLE,
        ST_WAIT
    } ecp_state_t;

endpackage : ecp_pkg
